// file: design/adcp_defines.svh
// adcp_defines.svh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the device and host design files
`ifndef ADCP_DEFINES_SVH
`define ADCP_DEFINES_SVH
// ---------------------------------------------------------------
// serial command word: [15] read, [14:8] address, [7:0] data
// ---------------------------------------------------------------
`define ADCP_SPI_W        16
`define ADCP_CFG_ADDR     7'h00
`define ADCP_CFG_RST      8'h00
`define ADCP_CFG_PD       0
`define ADCP_CFG_ONE_LANE 1
`define ADCP_CFG_HALF_I   2
`define ADCP_CFG_TERM     3
`define ADCP_CFG_DCS_OFF  4
// ---------------------------------------------------------------
// output framing
// ---------------------------------------------------------------
`define ADCP_SAMP_W       14
`define ADCP_BIT_CYC      4
`define ADCP_DCLK_PH      2
// ---------------------------------------------------------------
// host register offsets and fields
// ---------------------------------------------------------------
`define ADCP_H_CMD        4'h0
`define ADCP_H_STAT       4'h4
`define ADCP_H_PINS       4'h8
`define ADCP_P_STRAP      0
`define ADCP_P_CS         1
`define ADCP_P_SCK        2
`define ADCP_P_SDI        3
`define ADCP_P_SDO        4
`define ADCP_P_ENC_EN     5
`define ADCP_P_RX_ONE     6
// ---------------------------------------------------------------
// timing: clock period and serial clock half period in ns
// ---------------------------------------------------------------
`define ADCP_CLK_NS       10
`define ADCP_SCK_HALF_NS  130
`define ADCP_SCK_HALF_CYC ((`ADCP_SCK_HALF_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_ENC_HALF     40
`endif

// file: design/adcp_pkg.sv
// adcp_pkg.sv: sample type of both link ends, serial master state type of the host end
// assumes: nothing beyond the defines header
package adcp_pkg;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [13:0] adcp_smp_t;                     // one sample word
  typedef enum {SP_IDLE, SP_SETUP, SP_LOW, SP_HIGH, SP_HOLD} adcp_spi_st_t;
endpackage : adcp_pkg

// file: design/adcp_link_if.sv
// adcp_link_if.sv: pins between converter end and host end
// assumes: sdo has a pull-up; both ends drive it only through enables
`timescale 1ns/100ps
interface adcp_link_if;
  logic prog_mode_strap;            // 1 parallel, 0 serial
  logic encode_pos;                 // encode clock
  logic encode_neg;                 // encode complement
  logic cs_n;                       // select / lane count level
  logic sck;                        // serial clock / drive current level
  logic sdi;                        // serial data / power-down level
  logic dev_sdo_o;                  // device sdo drive value
  logic dev_sdo_oe;                 // device pulls sdo
  logic host_sdo_o;                 // host sdo drive value
  logic host_sdo_oe;                // host drives sdo
  logic sdo;                        // resolved sdo level
  logic data_clock_out;             // bit clock, both edges
  logic frame_marker;               // word start
  logic ch1_lane_a;                 // channel 1 lanes
  logic ch1_lane_b;
  logic ch2_lane_a;                 // channel 2 lanes
  logic ch2_lane_b;
  // pull-up wire: any low drive wins
  assign sdo = ~((dev_sdo_oe & ~dev_sdo_o) | (host_sdo_oe & ~host_sdo_o));
  modport dev  (input prog_mode_strap, encode_pos, encode_neg, cs_n, sck, sdi, sdo,
                output dev_sdo_o, dev_sdo_oe, data_clock_out, frame_marker,
                ch1_lane_a, ch1_lane_b, ch2_lane_a, ch2_lane_b);
  modport host (output prog_mode_strap, encode_pos, encode_neg, cs_n, sck, sdi,
                host_sdo_o, host_sdo_oe,
                input sdo, data_clock_out, frame_marker,
                ch1_lane_a, ch1_lane_b, ch2_lane_a, ch2_lane_b);
endinterface : adcp_link_if

// file: design/adcp_device.sv
// adcp_device.sv: converter end, configuration port and output framing
// assumes: link pins asynchronous to mclk; samples offered by user logic
// Functional notes
// - conversion starts on encode_pos rising
// - encode_neg falling pairs with that start
// - serial mode: sck shifts only while selected
// - sdi sampled on rising sck
// - readback bits ready for falling sck capture
// - sdo only pulls low, readback optional
// - parallel: cs_n level picks lane count
// - parallel: sck level picks drive current
// - parallel: sdi level powers down converter
// - parallel: sdo input enables output termination
// - strap low: pins form serial port
// - strap high: pins are static selects
// - board wires strap, never toggled
// - two lanes per channel, or lane a only
// - frame marker and data clock accompany data
// - receiver samples both clock edges, uses frame
// - parallel mode keeps duty stabiliser on
`timescale 1ns/100ps
`include "adcp_defines.svh"
module adcp_device
  import adcp_pkg::*;
#(
  parameter int BIT_CYC = `ADCP_BIT_CYC
) (
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      rst,
  // link
  adcp_link_if.dev       lnk,
  // sample source
  input  wire logic      smp_valid,
  output logic           smp_ready,
  input  wire adcp_smp_t smp_ch1,
  input  wire adcp_smp_t smp_ch2,
  // settings in force
  output logic           serial_mode,
  output logic           cfg_power_down,
  output logic           cfg_one_lane,
  output logic           cfg_half_current,
  output logic           cfg_term_en,
  output logic           cfg_dcs_en,
  output logic           conv_start
);
  // elaboration check
  if (BIT_CYC <= `ADCP_DCLK_PH || BIT_CYC > 256) begin : g_chk
    $error("adcp_device: BIT_CYC out of range");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pin_a_r;              // first stage, read by second only
  logic [6:0] pin_b_r;              // second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_a_r <= 7'h00;
      pin_b_r <= 7'h00;
    end else begin
      pin_a_r <= {lnk.prog_mode_strap, lnk.encode_pos, lnk.encode_neg,
                  lnk.cs_n, lnk.sck, lnk.sdi, lnk.sdo};
      pin_b_r <= pin_a_r;
    end
  end
  logic strap_s, pos_s, neg_s, cs_s, sck_s, sdi_s, sdo_s;
  assign {strap_s, pos_s, neg_s, cs_s, sck_s, sdi_s, sdo_s} = pin_b_r;

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  logic [1:0] strap_cnt_r;          // waits out the synchroniser
  logic       par_r;                // 1 parallel mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_cnt_r <= 2'h0;
      par_r       <= 1'b0;
    end else if (strap_cnt_r != 2'h3) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h2) par_r <= strap_s;
    end
  end
  assign serial_mode = ~par_r;

  // ---------------------------------------------------------------
  // serial port: shift in, write, readback
  // ---------------------------------------------------------------
  logic [14:0] sin_r;               // bits received so far
  logic [4:0]  scnt_r;              // rising edges seen
  logic [7:0]  sout_r;              // readback shifter
  logic        soe_r;               // readback active
  logic [7:0]  cfg_r;               // control register
  logic        sck_d_r;             // edge detect
  logic        srise;
  always_ff @(posedge mclk) begin
    if (rst) sck_d_r <= 1'b0;
    else     sck_d_r <= sck_s;
  end
  assign srise = serial_mode & ~cs_s & sck_s & ~sck_d_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sin_r  <= 15'h0000;
      scnt_r <= 5'h00;
      sout_r <= 8'h00;
      soe_r  <= 1'b0;
      cfg_r  <= `ADCP_CFG_RST;
    end else if (!serial_mode || cs_s) begin
      scnt_r <= 5'h00;
      soe_r  <= 1'b0;
    end else if (srise) begin
      sin_r <= {sin_r[13:0], sdi_s};
      if (scnt_r != 5'h10) scnt_r <= scnt_r + 5'h01;
      // address complete on the eighth edge: load readback
      if (scnt_r == 5'h07 && sin_r[6]) begin
        sout_r <= ({sin_r[5:0], sdi_s} == `ADCP_CFG_ADDR) ? cfg_r : 8'h00;
        soe_r  <= 1'b1;
      end else if (soe_r) begin
        sout_r <= {sout_r[6:0], 1'b1};
      end
      // write on the sixteenth edge
      if (scnt_r == 5'h0f && !sin_r[14] && sin_r[13:7] == `ADCP_CFG_ADDR)
        cfg_r <= {sin_r[6:0], sdi_s};
    end
  end
  // open drain: only ever pulls low
  assign lnk.dev_sdo_o  = 1'b0;
  assign lnk.dev_sdo_oe = serial_mode & ~cs_s & soe_r & ~sout_r[7];

  // ---------------------------------------------------------------
  // settings in force
  // ---------------------------------------------------------------
  always_comb begin
    if (par_r) begin
      cfg_one_lane     = cs_s;
      cfg_half_current = sck_s;
      cfg_power_down   = sdi_s;
      cfg_term_en      = sdo_s;
      cfg_dcs_en       = 1'b1;
    end else begin
      cfg_one_lane     = cfg_r[`ADCP_CFG_ONE_LANE];
      cfg_half_current = cfg_r[`ADCP_CFG_HALF_I];
      cfg_power_down   = cfg_r[`ADCP_CFG_PD];
      cfg_term_en      = cfg_r[`ADCP_CFG_TERM];
      cfg_dcs_en       = ~cfg_r[`ADCP_CFG_DCS_OFF];
    end
  end

  // ---------------------------------------------------------------
  // encode edge detection
  // ---------------------------------------------------------------
  logic enc_lvl;                    // high between the paired edges
  logic enc_d_r;
  assign enc_lvl = pos_s & ~neg_s;
  always_ff @(posedge mclk) begin
    if (rst) enc_d_r <= 1'b0;
    else     enc_d_r <= enc_lvl;
  end
  assign conv_start = enc_lvl & ~enc_d_r & ~cfg_power_down;

  // ---------------------------------------------------------------
  // two-entry sample buffer
  // ---------------------------------------------------------------
  logic [27:0] mem_r [2];           // entries
  logic        wp_r, rp_r;          // pointers
  logic [1:0]  bcnt_r;              // fill level
  logic        busy_r;              // serializer busy
  logic        push, pop;
  assign smp_ready = (bcnt_r != 2'h2);
  assign push      = smp_valid & smp_ready;
  assign pop       = conv_start & ~busy_r & (bcnt_r != 2'h0);
  for (genvar i = 0; i < 2; i++) begin : g_ent
    always_ff @(posedge mclk) begin
      if (rst)                    mem_r[i] <= 28'h0000000;
      else if (push && wp_r == i) mem_r[i] <= {smp_ch1, smp_ch2};
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      bcnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop)  rp_r <= ~rp_r;
      bcnt_r <= bcnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // ---------------------------------------------------------------
  // serializer: data at phase 0, clock edge mid-bit
  // ---------------------------------------------------------------
  logic [13:0] sh1_r, sh2_r;        // words being sent
  logic [7:0]  ph_r;                // phase within a bit
  logic [3:0]  bit_r;               // bit within a word
  logic        one_r;               // lane count latched per word
  logic [3:0]  last_bit;
  logic        dclk_r, frm_r, a1_r, b1_r, a2_r, b2_r;
  assign last_bit = one_r ? 4'hd : 4'h6;
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_r <= 1'b0;
      sh1_r  <= 14'h0000;
      sh2_r  <= 14'h0000;
      ph_r   <= 8'h00;
      bit_r  <= 4'h0;
      one_r  <= 1'b0;
      dclk_r <= 1'b0;
      frm_r  <= 1'b0;
      {a1_r, b1_r, a2_r, b2_r} <= 4'h0;
    end else if (pop) begin
      {sh1_r, sh2_r} <= mem_r[rp_r];
      one_r  <= cfg_one_lane;
      busy_r <= 1'b1;
      ph_r   <= 8'h00;
      bit_r  <= 4'h0;
    end else if (busy_r) begin
      ph_r <= (ph_r == 8'(BIT_CYC - 1)) ? 8'h00 : ph_r + 8'h01;
      if (ph_r == 8'h00) begin
        frm_r <= (bit_r == 4'h0);
        a1_r <= sh1_r[13];
        a2_r <= sh2_r[13];
        b1_r <= one_r ? 1'b0 : sh1_r[12];
        b2_r <= one_r ? 1'b0 : sh2_r[12];
        sh1_r <= one_r ? {sh1_r[12:0], 1'b0} : {sh1_r[11:0], 2'b00};
        sh2_r <= one_r ? {sh2_r[12:0], 1'b0} : {sh2_r[11:0], 2'b00};
      end
      if (ph_r == 8'(`ADCP_DCLK_PH)) dclk_r <= ~dclk_r;
      if (ph_r == 8'(BIT_CYC - 1)) begin
        bit_r <= bit_r + 4'h1;
        if (bit_r == last_bit) busy_r <= 1'b0;
      end
    end
  end
  assign lnk.data_clock_out = dclk_r;
  assign lnk.frame_marker   = frm_r;
  assign lnk.ch1_lane_a     = a1_r;
  assign lnk.ch1_lane_b     = b1_r;
  assign lnk.ch2_lane_a     = a2_r;
  assign lnk.ch2_lane_b     = b2_r;
endmodule : adcp_device

// file: design/adcp_host.sv
// adcp_host.sv: host end, serial master, pin levels, lane receiver
// assumes: link pins asynchronous to mclk; software on a plain register port
`timescale 1ns/100ps
`include "adcp_defines.svh"
module adcp_host
  import adcp_pkg::*;
#(
  parameter int ENC_HALF = `ADCP_ENC_HALF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // link
  adcp_link_if.host        lnk,
  // received samples
  output logic             smp_valid,
  input  wire logic        smp_ready,
  output adcp_smp_t        smp_ch1,
  output adcp_smp_t        smp_ch2
);
  if (ENC_HALF < 1 || ENC_HALF > 65536) begin : g_chk
    $error("adcp_host: ENC_HALF out of range");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pin_a_r, pin_b_r;     // first stage read by second only
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_a_r <= 6'h00;
      pin_b_r <= 6'h00;
    end else begin
      pin_a_r <= {lnk.sdo, lnk.data_clock_out, lnk.frame_marker,
                  lnk.ch1_lane_a, lnk.ch1_lane_b, lnk.ch2_lane_a};
      pin_b_r <= pin_a_r;
    end
  end
  logic b2_a_r, b2_b_r;             // lane 2b synchroniser
  always_ff @(posedge mclk) begin
    if (rst) {b2_a_r, b2_b_r} <= 2'h0;
    else     {b2_a_r, b2_b_r} <= {lnk.ch2_lane_b, b2_a_r};
  end
  logic sdo_s, dclk_s, frm_s, a1_s, b1_s, a2_s;
  assign {sdo_s, dclk_s, frm_s, a1_s, b1_s, a2_s} = pin_b_r;

  // ---------------------------------------------------------------
  // registers and serial master
  // ---------------------------------------------------------------
  logic [6:0]   pins_r;             // strap, static levels, enables
  logic [15:0]  cmd_r;              // outgoing word
  logic [7:0]   rb_r;               // readback byte
  logic         ovf_r;              // sticky: word lost
  adcp_spi_st_t st_r;
  logic [7:0]   tm_r;               // half period timer
  logic [3:0]   k_r;                // bit index
  logic         cs_r, sck_r, sdi_r;
  logic         tdone;
  assign tdone = (tm_r == 8'(`ADCP_SCK_HALF_CYC - 1));
  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_r <= 7'h02;
      cmd_r  <= 16'h0000;
      rb_r   <= 8'h00;
      st_r   <= SP_IDLE;
      tm_r   <= 8'h00;
      k_r    <= 4'h0;
      {cs_r, sck_r, sdi_r} <= 3'b100;
    end else begin
      if (wr && addr == `ADCP_H_PINS) pins_r <= wdata[6:0];
      tm_r <= (st_r == SP_IDLE || tdone) ? 8'h00 : tm_r + 8'h01;
      case (st_r)
        SP_IDLE: if (wr && addr == `ADCP_H_CMD && !pins_r[`ADCP_P_STRAP]) begin
          cmd_r <= wdata[15:0];
          cs_r  <= 1'b0;
          k_r   <= 4'h0;
          st_r  <= SP_SETUP;
        end
        SP_SETUP: if (tdone) begin
          sdi_r <= cmd_r[15];
          cmd_r <= {cmd_r[14:0], 1'b0};
          st_r  <= SP_LOW;
        end
        SP_LOW: if (tdone) begin
          sck_r <= 1'b1;
          st_r  <= SP_HIGH;
        end
        SP_HIGH: if (tdone) begin
          sck_r <= 1'b0;
          if (k_r >= 4'h7 && k_r != 4'hf) rb_r <= {rb_r[6:0], sdo_s};
          k_r   <= k_r + 4'h1;
          sdi_r <= cmd_r[15];
          cmd_r <= {cmd_r[14:0], 1'b0};
          st_r  <= (k_r == 4'hf) ? SP_HOLD : SP_LOW;
        end
        SP_HOLD: if (tdone) begin
          cs_r <= 1'b1;
          st_r <= SP_IDLE;
        end
        default: st_r <= SP_IDLE;
      endcase
    end
  end
  // strap is static; pins are levels in parallel mode
  assign lnk.prog_mode_strap = pins_r[`ADCP_P_STRAP];
  assign lnk.cs_n  = pins_r[`ADCP_P_STRAP] ? pins_r[`ADCP_P_CS]  : cs_r;
  assign lnk.sck   = pins_r[`ADCP_P_STRAP] ? pins_r[`ADCP_P_SCK] : sck_r;
  assign lnk.sdi   = pins_r[`ADCP_P_STRAP] ? pins_r[`ADCP_P_SDI] : sdi_r;
  assign lnk.host_sdo_o  = pins_r[`ADCP_P_SDO];
  assign lnk.host_sdo_oe = pins_r[`ADCP_P_STRAP];

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) rdata <= 32'h00000000;
    else if (rd) begin
      case (addr)
        `ADCP_H_STAT: rdata <= {22'h0, ovf_r, rb_r, st_r != SP_IDLE};
        `ADCP_H_PINS: rdata <= {25'h0, pins_r};
        default:      rdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // encode clock, paused while received words wait
  // ---------------------------------------------------------------
  logic [15:0] ediv_r;
  logic        enc_r;
  logic [1:0]  bcnt_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ediv_r <= 16'h0000;
      enc_r  <= 1'b0;
    end else if (ediv_r == 16'(ENC_HALF - 1)) begin
      ediv_r <= 16'h0000;
      if (enc_r || (pins_r[`ADCP_P_ENC_EN] && bcnt_r == 2'h0)) enc_r <= ~enc_r;
    end else begin
      ediv_r <= ediv_r + 16'h0001;
    end
  end
  assign lnk.encode_pos = enc_r;
  assign lnk.encode_neg = ~enc_r;

  // ---------------------------------------------------------------
  // lane receiver: both clock edges, frame resets count
  // ---------------------------------------------------------------
  logic [13:0] s1_r, s2_r;
  logic [3:0]  n_r;
  logic        dclk_d_r, got_r;
  logic        dedge;
  assign dedge = dclk_s ^ dclk_d_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      dclk_d_r <= 1'b0;
      s1_r <= 14'h0000;
      s2_r <= 14'h0000;
      n_r  <= 4'h0;
      got_r <= 1'b0;
    end else begin
      dclk_d_r <= dclk_s;
      got_r    <= 1'b0;
      if (dedge) begin
        n_r <= frm_s ? 4'h1 : n_r + 4'h1;
        if (pins_r[`ADCP_P_RX_ONE]) begin
          s1_r <= {s1_r[12:0], a1_s};
          s2_r <= {s2_r[12:0], a2_s};
          got_r <= (frm_s ? 4'h1 : n_r + 4'h1) == 4'he;
        end else begin
          s1_r <= {s1_r[11:0], a1_s, b1_s};
          s2_r <= {s2_r[11:0], a2_s, b2_b_r};
          got_r <= (frm_s ? 4'h1 : n_r + 4'h1) == 4'h7;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // two-entry output buffer
  // ---------------------------------------------------------------
  logic [27:0] mem_r [2];
  logic        wp_r, rp_r, push, pop;
  assign push = got_r & (bcnt_r != 2'h2);
  assign pop  = smp_valid & smp_ready;
  assign smp_valid = (bcnt_r != 2'h0);
  assign {smp_ch1, smp_ch2} = mem_r[rp_r];
  for (genvar i = 0; i < 2; i++) begin : g_ent
    always_ff @(posedge mclk) begin
      if (rst)                    mem_r[i] <= 28'h0000000;
      else if (push && wp_r == i) mem_r[i] <= {s1_r, s2_r};
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      bcnt_r <= 2'h0;
      ovf_r  <= 1'b0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop)  rp_r <= ~rp_r;
      bcnt_r <= bcnt_r + {1'b0, push} - {1'b0, pop};
      if (got_r && bcnt_r == 2'h2) ovf_r <= 1'b1;
      else if (rd && addr == `ADCP_H_STAT) ovf_r <= 1'b0;
    end
  end
endmodule : adcp_host

// file: dv/adcp_link_chk.sv
// adcp_link_chk.sv: assertions on the link pins driven by the converter end
// assumes: instantiated beside the link interface, all in the mclk domain
`timescale 1ns/100ps
module adcp_link_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration pins
  input wire logic prog_mode_strap,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe,
  // output stream
  input wire logic data_clock_out,
  input wire logic frame_marker,
  input wire logic ch1_lane_a,
  input wire logic ch1_lane_b,
  input wire logic ch2_lane_a,
  input wire logic ch2_lane_b
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // frame marker spans exactly one four-cycle bit
  sequence s_bit0; frame_marker [*4] ##1 !frame_marker; endsequence
  // bit clock moves mid-bit, two cycles after the data
  sequence s_dclk; ##2 $changed(data_clock_out); endsequence
  property p_sdo_low; dev_sdo_oe |-> !dev_sdo_o; endproperty
  property p_sdo_rel; cs_n [*6] |-> !dev_sdo_oe; endproperty
  property p_sdo_sel; $rose(dev_sdo_oe) |-> !cs_n && !prog_mode_strap; endproperty
  property p_sdo_fall; $fell(sck) |-> $stable(dev_sdo_oe); endproperty
  property p_par_sdo; prog_mode_strap [*4] |-> !dev_sdo_oe; endproperty
  property p_frame; $rose(frame_marker) |-> s_bit0; endproperty
  property p_lane; $changed(ch1_lane_a) |-> s_dclk; endproperty
  property p_dclk;
    $changed(data_clock_out) |-> $stable({ch1_lane_a, ch1_lane_b, ch2_lane_a, ch2_lane_b});
  endproperty
  a_sdo_low: assert property (p_sdo_low) else $error("sdo driven high");
  a_sdo_rel: assert property (p_sdo_rel) else $error("sdo held");
  a_sdo_sel: assert property (p_sdo_sel) else $error("sdo unselected");
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moves at fall");
  a_par_sdo: assert property (p_par_sdo) else $error("sdo driven parallel");
  a_frame: assert property (p_frame) else $error("frame width");
  a_lane: assert property (p_lane) else $error("no bit clock");
  a_dclk: assert property (p_dclk) else $error("lanes move at clock");
endmodule : adcp_link_chk

// file: dv/adc_mode_config_port_test.sv
// adc_mode_config_port_test.sv: both link ends joined, driven by register tasks
// assumes: design files and the checker are compiled first
`timescale 1ns/100ps
`include "adcp_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t %h %h", $time, (g), (e)); end end
module adc_mode_config_port_test
  import adcp_pkg::*;
;
  logic        mclk = 1'h0;   // system clock
  logic        rst = 1'h1;    // shared reset
  logic        rst_x = 1'h0;  // device-only reset
  logic        rst_dev;
  logic [3:0]  addr = 4'h0;   // register port
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [31:0] rdata;
  logic [31:0] rv;            // last value read
  logic        h_valid;       // received samples
  logic        h_ready = 1'h1;
  adcp_smp_t   h_ch1;
  adcp_smp_t   h_ch2;
  logic        ser, pd, one, half, term, dcs;
  logic        conv, d_ready; // start pulse, device buffer ready
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          starts = 0;    // conversion starts seen
  localparam adcp_smp_t smp_a = 14'h2a5c;  // fixed sample words
  localparam adcp_smp_t smp_b = 14'h15a3;
  assign rst_dev = rst | rst_x;
  adcp_link_if lnk ();
  adcp_device i_adcp_device (
    .mclk(mclk), .rst(rst_dev), .lnk(lnk), .smp_valid(1'h1), .smp_ready(d_ready),
    .smp_ch1(smp_a), .smp_ch2(smp_b), .serial_mode(ser), .cfg_power_down(pd),
    .cfg_one_lane(one), .cfg_half_current(half), .cfg_term_en(term),
    .cfg_dcs_en(dcs), .conv_start(conv));
  adcp_host i_adcp_host (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .lnk(lnk), .smp_valid(h_valid), .smp_ready(h_ready),
    .smp_ch1(h_ch1), .smp_ch2(h_ch2));
  adcp_link_chk i_adcp_link_chk (
    .mclk(mclk), .rst(rst_dev), .prog_mode_strap(lnk.prog_mode_strap),
    .cs_n(lnk.cs_n), .sck(lnk.sck), .dev_sdo_o(lnk.dev_sdo_o),
    .dev_sdo_oe(lnk.dev_sdo_oe), .data_clock_out(lnk.data_clock_out),
    .frame_marker(lnk.frame_marker), .ch1_lane_a(lnk.ch1_lane_a),
    .ch1_lane_b(lnk.ch1_lane_b), .ch2_lane_a(lnk.ch2_lane_a),
    .ch2_lane_b(lnk.ch2_lane_b));
  // clock and hang guard
  initial forever #5 mclk = ~mclk;
  // count start pulses mid-cycle, where they are settled
  always @(negedge mclk) begin
    if (conv === 1'h1) starts <= starts + 1;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // one-cycle register strobes
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg
  // serial command, then poll busy
  task automatic spi(input logic [15:0] w);
    wr_reg(`ADCP_H_CMD, {16'h0, w});
    rv = 32'h1;
    for (int i = 0; i < 400 && rv[0] === 1'h1; i++) rd_reg(`ADCP_H_STAT, rv);
    `CHK(rv[0], 1'h0)
  endtask : spi
  task automatic wait_valid();
    for (int i = 0; i < 3000 && h_valid !== 1'h1; i++) @(negedge mclk);
    `CHK(h_valid, 1'h1)
  endtask : wait_valid
  // stream words with a receiver stall, then stop encode and drain
  task automatic rx(input logic one_l, input logic [7:0] cfg);
    spi({8'h00, cfg});
    wr_reg(`ADCP_H_PINS, {25'h0, one_l, 6'h22});
    h_ready <= 1'h0;
    wait_valid();
    repeat (300) @(negedge mclk);
    `CHK({h_valid, h_ch1, h_ch2}, {1'h1, smp_a, smp_b})
    @(posedge mclk);
    h_ready <= 1'h1;
    repeat (2) @(negedge mclk);
    wait_valid();
    `CHK({h_ch1, h_ch2}, {smp_a, smp_b})
    wr_reg(`ADCP_H_PINS, 32'h2);
    repeat (300) @(posedge mclk);
  endtask : rx
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    rd_reg(`ADCP_H_PINS, rv);
    `CHK(rv, 32'h2)
    rd_reg(4'hc, rv);
    `CHK(rv, 32'h0)
    `CHK(d_ready, 1'h0)
    `CHK(ser, 1'h1)
    rx(1'h0, 8'h00);
    rx(1'h1, 8'h0e);
    `CHK(starts != 0, 1'h1)
    `CHK({one, half, term, pd, dcs}, 5'h1d)
    spi(16'h8000);
    `CHK(rv[9:1], 9'h00e)
    spi(16'h8500);
    `CHK(rv[8:1], 8'h00)
    spi(16'h05ff);
    spi(16'h8000);
    `CHK(rv[8:1], 8'h0e)
    spi(16'h001e);
    `CHK(dcs, 1'h0)
    wr_reg(`ADCP_H_PINS, 32'h17);
    rst_x <= 1'h1;
    repeat (3) @(posedge mclk);
    rst_x <= 1'h0;
    repeat (8) @(negedge mclk);
    `CHK({ser, one, half, term, pd, dcs}, 6'h1d)
    wr_reg(`ADCP_H_PINS, 32'h09);
    repeat (8) @(negedge mclk);
    `CHK({one, half, term, pd}, 4'h1)
    rv = starts;
    wr_reg(`ADCP_H_PINS, 32'h29);
    repeat (300) @(posedge mclk);
    `CHK(starts, rv)
    wr_reg(`ADCP_H_CMD, 32'h1f);
    rd_reg(`ADCP_H_STAT, rv);
    `CHK(rv[0], 1'h0)
    give_verdict();
  end
endmodule : adc_mode_config_port_test
